// ### twsx_exec.sv
// Execution logic for table write, test-skip-if-zero and the two xor instructions
`timescale 1ns/1ps
`default_nettype none
`include "twsx_params.svh"

module twsx_exec #(
  parameter int PTR_W = `TWSX_PTR_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Instruction from the fetch pipeline
  input wire twsx_pkg::twsx_fetch_type fetch,
  output logic fetch_ready,
  output logic flush,
  // Data register file
  output twsx_pkg::twsx_fsel_type freg_rd,
  input wire logic [7:0] freg_rdata,
  input wire logic [7:0] bank_select_reg,
  output logic [11:0] freg_addr_q,
  output logic freg_we_q,
  output logic [7:0] freg_wdata_q,
  // Table latch and holding registers
  input wire logic [7:0] table_latch,
  output twsx_pkg::twsx_hold_type hold_wr_q,
  output logic hold_high_byte_q,
  // Architectural state
  output logic [PTR_W-1:0] table_pointer_q,
  output logic [7:0] w_q,
  output logic flag_n_q,
  output logic flag_z_q,
  output logic skip_busy
);
  twsx_pkg::twsx_state_type state_q, state_d;
  logic [15:0] iw;
  logic is_tblw, is_tst, is_xorl, is_xorr;
  logic [1:0] mode_q;
  logic [7:0] xres;
  logic tst_zero;

  function automatic logic [11:0] bank_addr(input logic a, input logic [7:0] f,
                                            input logic [7:0] bank_sel);
    // Access bank: low half in bank 0, high half in bank 15
    if (!a) begin
      bank_addr = f[7] ? {4'hf, f} : {4'h0, f};
    end else begin
      bank_addr = {bank_sel[3:0], f};
    end
  endfunction

  // Steps wrap at either end of the PTR_W-bit pointer range, so a pointer walk never stalls
  function automatic logic [PTR_W-1:0] ptr_step(input logic [PTR_W-1:0] ptr,
                                                input logic up);
    ptr_step = up ? ptr + PTR_W'(1) : ptr - PTR_W'(1);
  endfunction

  assign iw = fetch.word;
  assign is_tblw = fetch.valid && state_q == twsx_pkg::ST_EXEC &&
                   (iw & `TWSX_TABLE_WRITE_MASK) == `TWSX_TABLE_WRITE_OPC;
  assign is_tst = fetch.valid && state_q == twsx_pkg::ST_EXEC &&
                  (iw[15:8] & `TWSX_TEST_SKIP_MASK) == `TWSX_TEST_SKIP_OPC;
  assign is_xorl = fetch.valid && state_q == twsx_pkg::ST_EXEC &&
                   iw[15:8] == `TWSX_XORLIT_OPC;
  assign is_xorr = fetch.valid && state_q == twsx_pkg::ST_EXEC &&
                   (iw[15:8] & `TWSX_XORREG_MASK) == `TWSX_XORREG_OPC;

  // Register read is combinational so the xor and test finish in their own cycle
  always_comb begin
    freg_rd.en = is_tst || is_xorr;
    freg_rd.addr = iw[7:0];
    freg_rd.access_bank = ~iw[`TWSX_BIT_ACCESS];
  end

  assign xres = is_xorl ? (w_q ^ iw[7:0]) : (w_q ^ freg_rdata);
  assign tst_zero = is_tst && freg_rdata == 8'h00;
  assign fetch_ready = state_q == twsx_pkg::ST_EXEC;
  assign skip_busy = state_q == twsx_pkg::ST_SKIP1 || state_q == twsx_pkg::ST_SKIP2;
  assign flush = tst_zero;

  always_comb begin
    state_d = state_q;
    case (state_q)
      twsx_pkg::ST_EXEC: begin
        if (is_tblw) begin
          state_d = twsx_pkg::ST_TBLW2;
        end else if (tst_zero) begin
          state_d = twsx_pkg::ST_SKIP1;
        end
      end
      twsx_pkg::ST_TBLW2: state_d = twsx_pkg::ST_EXEC;
      twsx_pkg::ST_SKIP1: begin
        state_d = fetch.next_two_word ? twsx_pkg::ST_SKIP2 : twsx_pkg::ST_EXEC;
      end
      twsx_pkg::ST_SKIP2: state_d = twsx_pkg::ST_EXEC;
      default: state_d = twsx_pkg::ST_EXEC;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_q <= twsx_pkg::ST_EXEC;
    end else begin
      state_q <= state_d;
    end
  end

  // Pointer: pre-increment moves before the transfer, post-increment and post-decrement after it, mode none holds
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      table_pointer_q <= `TWSX_PTR_RST;
      mode_q <= `TWSX_MODE_NONE;
    end else if (is_tblw) begin
      mode_q <= iw[1:0];
      if (iw[1:0] == `TWSX_MODE_PREINC) begin
        table_pointer_q <= ptr_step(table_pointer_q, 1'b1);
      end
    end else if (state_q == twsx_pkg::ST_TBLW2) begin
      case (mode_q)
        `TWSX_MODE_POSTINC: table_pointer_q <= ptr_step(table_pointer_q, 1'b1);
        `TWSX_MODE_POSTDEC: table_pointer_q <= ptr_step(table_pointer_q, 1'b0);
        default: table_pointer_q <= table_pointer_q;
      endcase
    end
  end

  // Holding write registered in the second cycle and issued in the next, from the pointer as it stands in the second cycle
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      hold_wr_q <= '0;
      hold_high_byte_q <= 1'b0;
    end else begin
      hold_wr_q.en <= state_q == twsx_pkg::ST_TBLW2;
      hold_wr_q.index <= table_pointer_q[2:0];
      hold_wr_q.data <= table_latch;
      hold_high_byte_q <= table_pointer_q[0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      w_q <= `TWSX_W_RST;
      flag_n_q <= 1'b0;
      flag_z_q <= 1'b0;
    end else if (is_xorl || is_xorr) begin
      flag_n_q <= xres[7];
      flag_z_q <= xres == 8'h00;
      if (is_xorl || !iw[`TWSX_BIT_DEST]) begin
        w_q <= xres;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      freg_we_q <= 1'b0;
      freg_addr_q <= 12'h000;
      freg_wdata_q <= 8'h00;
    end else begin
      freg_we_q <= is_xorr && iw[`TWSX_BIT_DEST];
      freg_addr_q <= bank_addr(iw[`TWSX_BIT_ACCESS], iw[7:0], bank_select_reg);
      freg_wdata_q <= xres;
    end
  end

  // Assertions
  property p_tblw_two_cycles;
    @(posedge clk) disable iff (!rst_b) is_tblw |=> state_q == twsx_pkg::ST_TBLW2 ##1 hold_wr_q.en;
  endproperty
  a_tblw_two_cycles: assert property (p_tblw_two_cycles) else $error("table write late");

  property p_hold_index;
    @(posedge clk) disable iff (!rst_b)
      state_q == twsx_pkg::ST_TBLW2 |=> hold_wr_q.index == $past(table_pointer_q[2:0]);
  endproperty
  a_hold_index: assert property (p_hold_index) else $error("holding index wrong");

  property p_postinc;
    @(posedge clk) disable iff (!rst_b)
      is_tblw && iw[1:0] == `TWSX_MODE_POSTINC |=>
        ##1 table_pointer_q == $past(table_pointer_q, 2) + PTR_W'(1);
  endproperty
  a_postinc: assert property (p_postinc) else $error("post-increment wrong");

  property p_postdec;
    @(posedge clk) disable iff (!rst_b)
      is_tblw && iw[1:0] == `TWSX_MODE_POSTDEC |=>
        ##1 table_pointer_q == $past(table_pointer_q, 2) - PTR_W'(1);
  endproperty
  a_postdec: assert property (p_postdec) else $error("post-decrement wrong");

  property p_skip_one;
    @(posedge clk) disable iff (!rst_b)
      tst_zero ##1 !fetch.next_two_word |=> state_q == twsx_pkg::ST_EXEC;
  endproperty
  a_skip_one: assert property (p_skip_one) else $error("skip length wrong");

  property p_skip_two;
    @(posedge clk) disable iff (!rst_b)
      tst_zero ##1 fetch.next_two_word |=> skip_busy ##1 !skip_busy;
  endproperty
  a_skip_two: assert property (p_skip_two) else $error("two-word skip wrong");

  property p_tst_no_write;
    @(posedge clk) disable iff (!rst_b) is_tst |=> !freg_we_q && $stable(flag_z_q);
  endproperty
  a_tst_no_write: assert property (p_tst_no_write) else $error("test wrote state");

  property p_xorl;
    @(posedge clk) disable iff (!rst_b)
      is_xorl |=> w_q == ($past(w_q) ^ $past(iw[7:0])) && flag_z_q == (w_q == 8'h00);
  endproperty
  a_xorl: assert property (p_xorl) else $error("literal xor wrong");

  property p_xorr_dest;
    @(posedge clk) disable iff (!rst_b)
      is_xorr && iw[`TWSX_BIT_DEST] |=> freg_we_q && $stable(w_q) && flag_n_q == freg_wdata_q[7];
  endproperty
  a_xorr_dest: assert property (p_xorr_dest) else $error("register xor wrong");

  c_tblw: cover property (@(posedge clk) disable iff (!rst_b) is_tblw ##2 hold_wr_q.en);
  c_skip2: cover property (@(posedge clk) disable iff (!rst_b) state_q == twsx_pkg::ST_SKIP2);
  c_xorr: cover property (@(posedge clk) disable iff (!rst_b) is_xorr ##1 freg_we_q);
endmodule
`default_nettype wire

// ### twsx_params.svh
// Constants for the table write, test-skip and xor execution block
`ifndef TWSX_PARAMS_SVH
`define TWSX_PARAMS_SVH
`define TWSX_TABLE_WRITE_OPC 16'h000c
`define TWSX_TABLE_WRITE_MASK 16'hfffc
`define TWSX_TEST_SKIP_OPC 8'h66
`define TWSX_TEST_SKIP_MASK 8'hfe
`define TWSX_XORLIT_OPC 8'h0a
`define TWSX_XORREG_OPC 8'h18
`define TWSX_XORREG_MASK 8'hfc
`define TWSX_PTR_W 21
`define TWSX_PTR_RST 21'h000000
`define TWSX_W_RST 8'h00
`define TWSX_BIT_ACCESS 8
`define TWSX_BIT_DEST 9
`define TWSX_MODE_NONE 2'h0
`define TWSX_MODE_POSTINC 2'h1
`define TWSX_MODE_POSTDEC 2'h2
`define TWSX_MODE_PREINC 2'h3
`endif

// ### twsx_pkg.sv
// Types for the table write, test-skip and xor execution block
`default_nettype none
package twsx_pkg;
  typedef enum logic [3:0] {
    ST_EXEC = 4'h1,
    ST_TBLW2 = 4'h2,
    ST_SKIP1 = 4'h4,
    ST_SKIP2 = 4'h8
  } twsx_state_type;
  typedef struct packed {
    logic valid;
    logic [15:0] word;
    logic next_two_word;
  } twsx_fetch_type;
  typedef struct packed {
    logic en;
    logic [7:0] addr;
    logic access_bank;
  } twsx_fsel_type;
  typedef struct packed {
    logic en;
    logic [2:0] index;
    logic [7:0] data;
  } twsx_hold_type;
endpackage
`default_nettype wire

// ### twsx_far_model.sv
// Register file and holding registers facing the execution block
`timescale 1ns/1ps
`default_nettype none
module twsx_far_model (
  // Clock
  input wire logic clk,
  // Register file
  input wire twsx_pkg::twsx_fsel_type freg_rd,
  input wire logic [7:0] bank_select_reg,
  input wire logic [11:0] freg_addr_q,
  input wire logic freg_we_q,
  input wire logic [7:0] freg_wdata_q,
  output logic [7:0] freg_rdata,
  // Holding registers
  input wire twsx_pkg::twsx_hold_type hold_wr_q
);
  logic [7:0] mem [4096];
  logic [7:0] hold [8];
  logic [11:0] ra;
  logic [7:0] junk_q = 8'h5a;
  // Access bank splits at 0x80 between bank 0 and bank 15
  assign ra = freg_rd.access_bank ? {{4{freg_rd.addr[7]}}, freg_rd.addr} :
    {bank_select_reg[3:0], freg_rd.addr};
  // Unselected reads show a changing pattern so stale data cannot pass
  assign freg_rdata = freg_rd.en ? mem[ra] : junk_q;
  // Plain always: the bench preloads the memory, which always_ff would forbid
  always @(posedge clk) begin
    junk_q <= ~junk_q;
    if (freg_we_q) mem[freg_addr_q] <= freg_wdata_q;
    if (hold_wr_q.en) hold[hold_wr_q.index] <= hold_wr_q.data;
  end
endmodule
`default_nettype wire

// ### twsx_exec_tb_top.sv
// Self-checking bench for the table write, test-skip and xor block
`timescale 1ns/1ps
`default_nettype none
module twsx_exec_tb_top;
  typedef struct packed {logic [15:0] wd; logic [7:0] w; logic [1:0] nz;} twsx_row_type;
  logic clk, rst_b, fetch_ready, flush, freg_we_q, hold_high_byte_q, flag_n_q, flag_z_q;
  logic skip_busy;
  twsx_pkg::twsx_fetch_type fetch;
  twsx_pkg::twsx_fsel_type freg_rd;
  twsx_pkg::twsx_hold_type hold_wr_q;
  logic [7:0] freg_rdata, bank_select_reg, freg_wdata_q, table_latch, w_q;
  logic [11:0] freg_addr_q;
  logic [20:0] table_pointer_q, p;
  int err_count = 0;
  int tests_run = 0;
  int cyc = 0;
  twsx_row_type rows [7] = '{'{16'h0aaf, 8'haf, 2'h2}, '{16'h0aaf, 8'h00, 2'h1},
    '{16'h0ab5, 8'hb5, 2'h2}, '{16'h0aaf, 8'h1a, 2'h0}, '{16'h1810, 8'h00, 2'h1},
    '{16'h1920, 8'h5a, 2'h0}, '{16'h1880, 8'h9a, 2'h2}};
  logic [1:0] md [7] = '{2'h0, 2'h1, 2'h3, 2'h2, 2'h2, 2'h2, 2'h1};

  twsx_exec i_dut (.clk(clk), .rst_b(rst_b), .fetch(fetch), .fetch_ready(fetch_ready),
    .flush(flush), .freg_rd(freg_rd), .freg_rdata(freg_rdata),
    .bank_select_reg(bank_select_reg), .freg_addr_q(freg_addr_q), .freg_we_q(freg_we_q),
    .freg_wdata_q(freg_wdata_q), .table_latch(table_latch), .hold_wr_q(hold_wr_q),
    .hold_high_byte_q(hold_high_byte_q), .table_pointer_q(table_pointer_q), .w_q(w_q),
    .flag_n_q(flag_n_q), .flag_z_q(flag_z_q), .skip_busy(skip_busy));
  twsx_far_model i_far (.clk(clk), .freg_rd(freg_rd), .bank_select_reg(bank_select_reg),
    .freg_addr_q(freg_addr_q), .freg_we_q(freg_we_q), .freg_wdata_q(freg_wdata_q),
    .freg_rdata(freg_rdata), .hold_wr_q(hold_wr_q));

  always #12.5 clk = ~clk;
  // Whole run needs well under 200 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      err_count++;
      final_report();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Valid stays as given so back-to-back words need no release in between
  task automatic drv(input logic v, input logic [15:0] wd, input logic two);
    fetch = '{v, wd, two};
    @(negedge clk);
  endtask
  task automatic skip(input logic [15:0] wd, input logic two, input int n);
    fetch = '{1'h1, wd, two};
    #1 chk("flush", flush, n != 0);
    @(negedge clk);
    fetch = '{1'h0, 16'h0aff, two};
    repeat (n) begin
      chk("busy", {skip_busy, fetch_ready}, 2'h2);
      @(negedge clk);
    end
    chk("busy", {skip_busy, fetch_ready}, 2'h1);
    chk("nzwe", {flag_n_q, flag_z_q, freg_we_q}, 3'h4);
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    clk = 1'h0;
    rst_b = 1'h0;
    fetch = '0;
    table_latch = 8'h00;
    bank_select_reg = 8'h03;
    p = 21'h000000;
    i_far.mem[12'h010] = 8'h1a;
    i_far.mem[12'h320] = 8'h5a;
    i_far.mem[12'hf80] = 8'hc0;
    i_far.mem[12'h330] = 8'h0f;
    i_far.mem[12'h340] = 8'h07;
    i_far.mem[12'h050] = 8'h00;
    repeat (8) @(negedge clk);
    rst_b = 1'h1;
    foreach (rows[i]) begin
      drv(1'h1, rows[i].wd, 1'h0);
      chk("w", w_q, rows[i].w);
      chk("nz", {flag_n_q, flag_z_q}, rows[i].nz);
      chk("we", freg_we_q, 1'h0);
    end
    $display("xor rows done");
    drv(1'h1, 16'h1a80, 1'h0);
    chk("wr", {freg_we_q, freg_addr_q, freg_wdata_q, w_q}, 29'h1f805a9a);
    chk("nz", {flag_n_q, flag_z_q}, 2'h0);
    drv(1'h1, 16'h1b30, 1'h0);
    chk("wr", {freg_we_q, freg_addr_q, freg_wdata_q, w_q}, 29'h1330959a);
    chk("nz", {flag_n_q, flag_z_q}, 2'h2);
    drv(1'h0, 16'h0000, 1'h0);
    chk("mem", {freg_we_q, i_far.mem[12'h330], i_far.mem[12'hf80]}, 17'h0955a);
    $display("register write done");
    foreach (md[k]) begin
      table_latch = 8'h30 ^ 8'(k);
      if (md[k] == 2'h3) p = p + 21'h000001;
      drv(1'h1, {14'h0003, md[k]}, 1'h0);
      chk("ready", fetch_ready, 1'h0);
      drv(1'h1, 16'h0aff, 1'h0);
      chk("hold", {hold_wr_q.en, hold_wr_q.index}, {1'h1, p[2:0]});
      chk("hdata", hold_wr_q.data, table_latch);
      chk("byte", hold_high_byte_q, p[0]);
      if (md[k] == 2'h1) p = p + 21'h000001;
      if (md[k] == 2'h2) p = p - 21'h000001;
      chk("ptr", table_pointer_q, p);
      chk("w", {w_q, flag_n_q, flag_z_q}, 10'h26a);
    end
    $display("table write done");
    skip(16'h6740, 1'h0, 0);
    skip(16'h6650, 1'h0, 1);
    skip(16'h6650, 1'h1, 2);
    $display("skip done");
    chk("held", {i_far.hold[0], i_far.hold[1]}, 16'h3534);
    chk("held", {i_far.hold[2], i_far.hold[7]}, 16'h3336);
    // Reset lands in the second cycle of a pre-increment table write
    drv(1'h1, 16'h000f, 1'h0);
    chk("ptr", table_pointer_q, 21'h000001);
    rst_b = 1'h0;
    @(negedge clk);
    chk("reset", {w_q, table_pointer_q, fetch_ready}, 30'h00000001);
    chk("rflags", {flag_n_q, flag_z_q, hold_wr_q.en, freg_we_q}, 4'h0);
    rst_b = 1'h1;
    drv(1'h1, 16'h0a3c, 1'h0);
    chk("w", {w_q, flag_n_q, flag_z_q}, 10'h0f0);
    $display("reset done");
    final_report();
  end
endmodule
`default_nettype wire
